// [spss_pkg.sv]
// Package: constants, types and register map of the strap sampler
package spss_pkg;

  // ==========================================================
  // Geometry
  localparam int SPSS_PAIRS = 4;
  localparam int SPSS_LANES = 4;

  // ==========================================================
  // Timing
  localparam int SPSS_CLK_MHZ = 100;
  localparam int SPSS_HOLD_CYC = 10;
  localparam int SPSS_RATE_MULT = 10;
  localparam logic [3:0] SPSS_CNT_LAST = 4'h9;

  // ==========================================================
  // Rate codes
  localparam logic [1:0] SPSS_RATE_B_DIV2 = 2'h0;
  localparam logic [1:0] SPSS_RATE_B = 2'h1;
  localparam logic [1:0] SPSS_RATE_A = 2'h2;
  localparam logic [1:0] SPSS_RATE_RSVD = 2'h3;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] SPSS_REG_CLKSEL = 8'h00;
  localparam logic [7:0] SPSS_REG_STRAP = 8'h04;
  localparam logic [7:0] SPSS_REG_STATUS = 8'h08;
  localparam logic [7:0] SPSS_REG_TEST = 8'h0C;

  // CLKSEL fields
  localparam int SPSS_F_RATE_LSB = 0;
  localparam int SPSS_F_PDOV_EN = 4;
  localparam int SPSS_F_PAIR_PD = 8;
  localparam int SPSS_F_ODD_PD = 12;
  localparam int SPSS_F_ODDOV_EN = 16;

  localparam logic [1:0] SPSS_RESP_OKAY = 2'h0;
  localparam logic [1:0] SPSS_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SPSS_ST_IDLE,
    SPSS_ST_SAMPLE,
    SPSS_ST_HOLD
  } spss_state_t;

  // Sampled strap image
  typedef struct packed {
    logic [SPSS_PAIRS-1:0] mode_1x;
    logic [SPSS_PAIRS-1:0] even_pd;
    logic [SPSS_PAIRS-1:0] odd_pd;
    logic [1:0] rate;
  } spss_straps_t;

  // Per port outputs
  typedef struct packed {
    logic [SPSS_PAIRS-1:0] four_lane;
    logic [SPSS_PAIRS-1:0] odd_avail;
    logic [SPSS_PAIRS-1:0] even_pd;
    logic [SPSS_PAIRS-1:0] odd_pd;
  } spss_port_cfg_t;

endpackage : spss_pkg

// [spss_pair_cfg.sv]
// Per-pair lane mode and power-down decode
`timescale 1ns/1ps
module spss_pair_cfg
  import spss_pkg::*;
(
  input wire logic mode_1x,
  input wire logic even_pd_in,
  input wire logic odd_pd_in,
  output logic four_lane,
  output logic odd_avail,
  output logic even_pd,
  output logic odd_pd,
  output logic [SPSS_LANES-1:0] lane_pd
);

  assign four_lane = ~mode_1x;
  assign odd_avail = mode_1x;
  assign even_pd = even_pd_in;
  // Even power-down forces the odd port down too
  assign odd_pd = even_pd_in | odd_pd_in;
  // Whole macro at once, never single lanes
  assign lane_pd = {SPSS_LANES{even_pd_in}};

endmodule : spss_pair_cfg

// [spss_strap_sampler.sv]
// Top: strap sampling, holding, overrides and AXI4-Lite registers
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module spss_strap_sampler
  import spss_pkg::*;
#(
  parameter int PAIRS = SPSS_PAIRS
)(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic self_reset,
  input wire logic [SPSS_PAIRS-1:0] pair_lane_mode_strap_i,
  input wire logic [SPSS_PAIRS-1:0] even_port_power_down_strap_i,
  input wire logic [SPSS_PAIRS-1:0] odd_port_power_down_strap_i,
  input wire logic [1:0] lane_rate_select_strap_i,
  output logic [SPSS_PAIRS-1:0] pair_lane_mode_strap_o,
  output logic [SPSS_PAIRS-1:0] even_port_power_down_strap_o,
  output logic [SPSS_PAIRS-1:0] odd_port_power_down_strap_o,
  output logic [1:0] lane_rate_select_strap_o,
  output logic [SPSS_PAIRS-1:0] pair_lane_mode_strap_oe,
  output logic [SPSS_PAIRS-1:0] even_port_power_down_strap_oe,
  output logic [SPSS_PAIRS-1:0] odd_port_power_down_strap_oe,
  output logic [1:0] lane_rate_select_strap_oe,
  output spss_port_cfg_t port_cfg,
  output logic [SPSS_PAIRS*SPSS_LANES-1:0] lane_power_down,
  output logic [1:0] lane_ref_sel,
  output logic [4:0] lane_rate_mult,
  output logic straps_valid,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================================
  // Sampling window; counted in bus clocks, which must not exceed 100 MHz
  localparam int WIN_NS = SPSS_HOLD_CYC * 1000 / SPSS_CLK_MHZ;

  spss_state_t st_ff;
  spss_state_t nxt_st;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  spss_straps_t strap_ff;
  spss_straps_t live;
  logic [1:0] rate_ff;
  logic win_end;

  assign live.mode_1x = pair_lane_mode_strap_i;
  assign live.even_pd = even_port_power_down_strap_i;
  assign live.odd_pd = odd_port_power_down_strap_i;
  assign live.rate = lane_rate_select_strap_i;

  // Last cycle of the hold window after reset release
  assign win_end = (st_ff == SPSS_ST_SAMPLE) && (cnt_ff == SPSS_CNT_LAST);

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    case (st_ff)
      SPSS_ST_IDLE: begin
        nxt_st = SPSS_ST_SAMPLE;
        nxt_cnt = 4'h0;
      end
      SPSS_ST_SAMPLE: begin
        nxt_cnt = cnt_ff + 4'h1;
        if (win_end) begin
          nxt_st = SPSS_ST_HOLD;
        end
      end
      SPSS_ST_HOLD: begin
        nxt_st = SPSS_ST_HOLD;
      end
      default: begin
        nxt_st = SPSS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_ff <= SPSS_ST_IDLE;
      cnt_ff <= 4'h0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
    end
  end

  // Straps captured at the window's end, then ignored until hard reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      strap_ff <= '0;
    end else if (win_end) begin
      strap_ff <= live;
    end
  end

  assign straps_valid = (st_ff == SPSS_ST_HOLD);

  // ==========================================================
  // Registers
  logic pdov_en_ff;
  logic oddov_en_ff;
  logic [SPSS_PAIRS-1:0] pair_pd_ff;
  logic [SPSS_PAIRS-1:0] odd_pd_sw_ff;
  logic test_mode_ff;
  logic [1:0] rate_fix;

  // Reserved code would leave the lanes without a clock
  assign rate_fix = (strap_ff.rate == SPSS_RATE_RSVD) ?
                    SPSS_RATE_B : strap_ff.rate;

  // Applied anew at the window's end after hard reset release and on each cycle that self_reset is high
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rate_ff <= SPSS_RATE_B;
    end else if (win_end) begin
      rate_ff <= (live.rate == SPSS_RATE_RSVD) ?
                 SPSS_RATE_B : live.rate;
    end else if (self_reset) begin
      rate_ff <= rate_fix;
    end
  end

  assign lane_ref_sel = rate_ff;
  assign lane_rate_mult = 5'(SPSS_RATE_MULT);

  // ==========================================================
  // Effective power-down after software override
  logic [SPSS_PAIRS-1:0] even_eff;
  logic [SPSS_PAIRS-1:0] odd_eff;
  assign even_eff = pdov_en_ff ? pair_pd_ff : strap_ff.even_pd;
  assign odd_eff = oddov_en_ff ? odd_pd_sw_ff : strap_ff.odd_pd;

  genvar gi;
  generate
    for (gi = 0; gi < SPSS_PAIRS; gi++) begin : g_pair
      spss_pair_cfg u_pair (
        .mode_1x(strap_ff.mode_1x[gi]),
        .even_pd_in(even_eff[gi]),
        .odd_pd_in(odd_eff[gi]),
        .four_lane(port_cfg.four_lane[gi]),
        .odd_avail(port_cfg.odd_avail[gi]),
        .even_pd(port_cfg.even_pd[gi]),
        .odd_pd(port_cfg.odd_pd[gi]),
        .lane_pd(lane_power_down[gi*SPSS_LANES +: SPSS_LANES])
      );
    end
  endgenerate

  // ==========================================================
  // Pins drive back the held image only in test mode
  assign pair_lane_mode_strap_o = strap_ff.mode_1x;
  assign even_port_power_down_strap_o = strap_ff.even_pd;
  assign odd_port_power_down_strap_o = strap_ff.odd_pd;
  assign lane_rate_select_strap_o = strap_ff.rate;
  assign pair_lane_mode_strap_oe = {SPSS_PAIRS{test_mode_ff}};
  assign even_port_power_down_strap_oe = {SPSS_PAIRS{test_mode_ff}};
  assign odd_port_power_down_strap_oe = {SPSS_PAIRS{test_mode_ff}};
  assign lane_rate_select_strap_oe = {2{test_mode_ff}};

  // ==========================================================
  // AXI4-Lite write
  logic aw_ff;
  logic w_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  // Strobes travel with the data; the master may drop them once w is taken
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic wr_go;
  logic wr_hit;

  assign s_axi_awready = ~aw_ff & ~bvalid_ff;
  assign s_axi_wready = ~w_ff & ~bvalid_ff;
  assign wr_go = aw_ff & w_ff & ~bvalid_ff;
  assign wr_hit = (awaddr_ff == SPSS_REG_CLKSEL) ||
                  (awaddr_ff == SPSS_REG_TEST);
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= SPSS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ff <= 1'b1;
        awaddr_ff <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? SPSS_RESP_OKAY : SPSS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Byte lanes 0..2 hold every writable field
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pdov_en_ff <= 1'b0;
      oddov_en_ff <= 1'b0;
      pair_pd_ff <= '0;
      odd_pd_sw_ff <= '0;
      test_mode_ff <= 1'b0;
    end else if (wr_go && awaddr_ff == SPSS_REG_CLKSEL) begin
      if (wstrb_ff[0]) begin
        pdov_en_ff <= wdata_ff[SPSS_F_PDOV_EN];
      end
      if (wstrb_ff[1]) begin
        pair_pd_ff <= wdata_ff[SPSS_F_PAIR_PD +: SPSS_PAIRS];
        odd_pd_sw_ff <= wdata_ff[SPSS_F_ODD_PD +: SPSS_PAIRS];
      end
      if (wstrb_ff[2]) begin
        oddov_en_ff <= wdata_ff[SPSS_F_ODDOV_EN];
      end
    end else if (wr_go && awaddr_ff == SPSS_REG_TEST && wstrb_ff[0]) begin
      test_mode_ff <= wdata_ff[0];
    end
  end

  // ==========================================================
  // AXI4-Lite read
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [7:0] ra;
  logic [31:0] rd_clksel;
  logic [31:0] rd_strap;
  logic [31:0] rd_status;
  logic rd_hit;

  assign ra = {s_axi_araddr[7:2], 2'b00};
  // Rate field reads back the applied rate, with the reserved code replaced by rate B
  assign rd_clksel = {15'h0000, oddov_en_ff, odd_pd_sw_ff,
                      pair_pd_ff, 3'h0, pdov_en_ff, 2'h0,
                      rate_ff};
  assign rd_strap = {18'h0_0000, strap_ff.rate, strap_ff.odd_pd,
                     strap_ff.even_pd, strap_ff.mode_1x};
  assign rd_status = {19'h0_0000, straps_valid, port_cfg.odd_pd,
                      port_cfg.even_pd, port_cfg.four_lane};
  assign rd_hit = (ra == SPSS_REG_CLKSEL) || (ra == SPSS_REG_STRAP) ||
                  (ra == SPSS_REG_STATUS) || (ra == SPSS_REG_TEST);
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= SPSS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= rd_hit ? SPSS_RESP_OKAY : SPSS_RESP_SLVERR;
      case (ra)
        SPSS_REG_CLKSEL: rdata_ff <= rd_clksel;
        SPSS_REG_STRAP: rdata_ff <= rd_strap;
        SPSS_REG_STATUS: rdata_ff <= rd_status;
        SPSS_REG_TEST: rdata_ff <= {31'h0000_0000, test_mode_ff};
        default: rdata_ff <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

endmodule : spss_strap_sampler

// [spss_board_model.sv]
// Board side of the strap pins: resistor values and pin resolution
`timescale 1ns/1ps
module spss_board_model
  import spss_pkg::*;
(
  input wire spss_straps_t board,
  input wire spss_straps_t dev_o,
  input wire spss_straps_t dev_oe,
  output spss_straps_t pin
);
  // ==========================================================
  // Straps
  spss_straps_t brd;
  // Four-lane pairs never use the odd port, so the board straps it down
  assign brd = {board.mode_1x, board.even_pd,
    board.odd_pd | ~board.mode_1x, board.rate};
  // Resistor level unless the device enables its driver
  assign pin = (dev_oe & dev_o) | (~dev_oe & brd);
endmodule : spss_board_model

// [spss_strap_sampler_asserts.sv]
// Checker: port properties of the strap sampler
`timescale 1ns/1ps
module spss_strap_sampler_asserts
  import spss_pkg::*;
#(
  parameter int PAIRS = SPSS_PAIRS
)(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [SPSS_PAIRS-1:0] pair_lane_mode_strap_i,
  input wire logic [1:0] lane_rate_select_strap_i,
  input wire logic [SPSS_PAIRS-1:0] pair_lane_mode_strap_o,
  input wire logic [SPSS_PAIRS-1:0] pair_lane_mode_strap_oe,
  input wire logic [SPSS_PAIRS-1:0] even_port_power_down_strap_oe,
  input wire logic [SPSS_PAIRS-1:0] odd_port_power_down_strap_oe,
  input wire logic [1:0] lane_rate_select_strap_oe,
  input wire spss_port_cfg_t port_cfg,
  input wire logic [SPSS_PAIRS*SPSS_LANES-1:0] lane_power_down,
  input wire logic [1:0] lane_ref_sel,
  input wire logic [4:0] lane_rate_mult,
  input wire logic straps_valid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp
);
  // ==========================================================
  // Helpers
  logic [13:0] oes;
  logic [3:0] e;
  assign oes = {pair_lane_mode_strap_oe, even_port_power_down_strap_oe,
    odd_port_power_down_strap_oe, lane_rate_select_strap_oe};
  assign e = port_cfg.even_pd;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // ==========================================================
  // Properties
  AST_WINDOW:
    assert property ($fell(rst) |-> !straps_valid [*8] ##1
      !straps_valid [*3] ##1 straps_valid) else $error("window length");
  AST_CAPTURE:
    assert property ($rose(straps_valid) |-> lane_ref_sel ==
      ($past(lane_rate_select_strap_i) == SPSS_RATE_RSVD ? SPSS_RATE_B :
      $past(lane_rate_select_strap_i)) && pair_lane_mode_strap_o ==
      $past(pair_lane_mode_strap_i)) else $error("capture value");
  AST_HOLD:
    assert property ($past(straps_valid) |-> $stable(lane_ref_sel) &&
      $stable(pair_lane_mode_strap_o)) else $error("held value moved");
  AST_MODE:
    assert property (port_cfg.four_lane == ~pair_lane_mode_strap_o &&
      port_cfg.odd_avail == pair_lane_mode_strap_o) else $error("mode");
  AST_PAIR_PD:
    assert property ((port_cfg.even_pd & ~port_cfg.odd_pd) == 4'h0)
      else $error("even down leaves odd up");
  AST_LANES:
    assert property (lane_power_down == {{4{e[3]}}, {4{e[2]}}, {4{e[1]}},
      {4{e[0]}}}) else $error("lane power down");
  AST_RATE_X10:
    assert property (lane_rate_mult == 5'h0a) else $error("rate mult");
  AST_NO_RSVD:
    assert property (lane_ref_sel != SPSS_RATE_RSVD) else $error("rsvd");
  AST_OE:
    assert property ($changed(oes) |-> $rose(s_axi_bvalid))
      else $error("pin drive changed without a write");
  AST_BHOLD:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
      $stable(s_axi_bresp)) else $error("write response dropped");
  COV_CAPTURE: cover property ($rose(straps_valid));
  COV_TEST: cover property (|oes);
  COV_ERR: cover property (s_axi_bvalid && s_axi_bresp == SPSS_RESP_SLVERR);
endmodule : spss_strap_sampler_asserts

bind spss_strap_sampler spss_strap_sampler_asserts #(.PAIRS(PAIRS))
  spss_chk_i (.*);

// [tb_top.sv]
// Testbench: strap capture, hold, overrides, test drive, register bus
`timescale 1ns/1ps
module tb_top;
  import spss_pkg::*;
  typedef struct packed {
    spss_straps_t b;
    spss_port_cfg_t cfg;
    logic [1:0] ref_sel;
  } spss_row_t;
  // ==========================================================
  // Rows: board straps, expected config, applied rate
  localparam spss_row_t ROWS [4] = '{
    {4'hf, 4'h0, 4'h0, 2'h0, 4'h0, 4'hf, 4'h0, 4'h0, 2'h0},
    {4'ha, 4'h0, 4'h5, 2'h1, 4'h5, 4'ha, 4'h0, 4'h5, 2'h1},
    {4'hf, 4'h3, 4'h4, 2'h2, 4'h0, 4'hf, 4'h3, 4'h7, 2'h2},
    {4'h0, 4'h8, 4'h0, 2'h3, 4'hf, 4'h0, 4'h8, 4'hf, 2'h1}};
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic self_reset = 1'b0;
  spss_straps_t board = '0;
  wire spss_straps_t pin, dev_o, dev_oe;
  spss_port_cfg_t port_cfg;
  logic [15:0] lane_power_down;
  logic [1:0] lane_ref_sel, s_axi_bresp, s_axi_rresp, r;
  logic straps_valid, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  int bad_count = 0;
  int n_tests = 0;

  always #5 sys_clk = ~sys_clk;

  spss_board_model spss_board_model_i (.board(board), .dev_o(dev_o),
    .dev_oe(dev_oe), .pin(pin));
  spss_strap_sampler spss_strap_sampler_i (
    .sys_clk(sys_clk), .rst(rst), .self_reset(self_reset),
    .pair_lane_mode_strap_i(pin.mode_1x),
    .even_port_power_down_strap_i(pin.even_pd),
    .odd_port_power_down_strap_i(pin.odd_pd),
    .lane_rate_select_strap_i(pin.rate),
    .pair_lane_mode_strap_o(dev_o.mode_1x),
    .even_port_power_down_strap_o(dev_o.even_pd),
    .odd_port_power_down_strap_o(dev_o.odd_pd),
    .lane_rate_select_strap_o(dev_o.rate),
    .pair_lane_mode_strap_oe(dev_oe.mode_1x),
    .even_port_power_down_strap_oe(dev_oe.even_pd),
    .odd_port_power_down_strap_oe(dev_oe.odd_pd),
    .lane_rate_select_strap_oe(dev_oe.rate),
    .port_cfg(port_cfg), .lane_power_down(lane_power_down),
    .lane_ref_sel(lane_ref_sel), .lane_rate_mult(),
    .straps_valid(straps_valid),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

  // ==========================================================
  // Tasks
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic hang();
    bad_count++;
    stop_test();
  endtask : hang

  task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask : chk

  function automatic logic [15:0] lanes(input logic [3:0] e);
    for (int p = 0; p < 4; p++) lanes[4*p +: 4] = {4{e[p]}};
  endfunction : lanes

  task automatic do_reset(input spss_straps_t b);
    board <= b;
    rst <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 20 && straps_valid !== 1'b1; i++) @(negedge sys_clk);
    if (straps_valid !== 1'b1) hang();
    @(posedge sys_clk);
  endtask : do_reset

  // Readiness is sampled mid-cycle, where nothing is moving
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
      output logic [1:0] rs);
    logic aw, w, b;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b = 1'b0;
    for (int i = 0; i < 40 && !b; i++) begin
      @(negedge sys_clk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge sys_clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (!b) hang();
    // Let an edge pass so a following call never re-drives bready at once
    @(posedge sys_clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v,
      output logic [1:0] rs);
    logic ar, ok;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    ok = 1'b0;
    for (int i = 0; i < 40 && !ok; i++) begin
      @(negedge sys_clk);
      ar = s_axi_arvalid & s_axi_arready;
      ok = s_axi_rvalid;
      v = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge sys_clk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (!ok) hang();
    @(posedge sys_clk);
  endtask : axi_rd

  // ==========================================================
  // Sequence
  initial begin
    for (int k = 0; k < 4; k++) begin
      do_reset(ROWS[k].b);
      chk("port_cfg", ROWS[k].cfg, port_cfg);
      chk("lane_pd", lanes(ROWS[k].cfg.even_pd), lane_power_down);
      chk("ref_sel", ROWS[k].ref_sel, lane_ref_sel);
      chk("oe", '0, dev_oe);
      axi_rd(SPSS_REG_CLKSEL, d, r);
      chk("clksel", {30'h0, ROWS[k].ref_sel}, d);
    end
    board <= '1;
    repeat (4) @(posedge sys_clk);
    chk("held_cfg", ROWS[3].cfg, port_cfg);
    chk("held_rate", SPSS_RATE_B, lane_ref_sel);
    self_reset <= 1'b1;
    @(posedge sys_clk);
    self_reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("self_rst_rate", SPSS_RATE_B, lane_ref_sel);
    axi_wr(SPSS_REG_CLKSEL, 32'h0001_1216, r);
    chk("wr_resp", SPSS_RESP_OKAY, r);
    chk("even_ovr", 4'h2, port_cfg.even_pd);
    chk("odd_ovr", 4'h3, port_cfg.odd_pd);
    axi_rd(SPSS_REG_CLKSEL, d, r);
    chk("clksel_ro", 32'h0001_1211, d);
    axi_rd(8'h10, d, r);
    chk("rd_err", SPSS_RESP_SLVERR, r);
    chk("rd_err_data", 32'h0000_0000, d);
    axi_wr(8'h10, 32'hffff_ffff, r);
    chk("wr_err", SPSS_RESP_SLVERR, r);
    axi_wr(SPSS_REG_TEST, 32'h0000_0001, r);
    chk("oe_test", 14'h3fff, dev_oe);
    chk("pin_drive", 4'h0, pin.mode_1x);
    axi_wr(SPSS_REG_TEST, 32'h0000_0000, r);
    chk("oe_off", '0, dev_oe);
    stop_test();
  end
endmodule : tb_top
